// File: logic/tmr8_core.sv
// 8-bit timer core: counter, two compare units, force compare, pin override.
// Assumes settings arrive as plain ports and the pin is synchronous.
// What this block does
// - Clock select zero stops counting; CPU counter writes still land.
// - CPU counter write beats any hardware update.
// - Each tick clears, increments or decrements counter.
// - Three-bit waveform mode from control A/B.
// - Compare equality sets flag on next tick.
// - Flag raises request; clears on ack or write-one.
// - PWM modes double-buffer compares, update at top.
// - CPU compare writes go to buffer when buffering.
// - Force match updates output only, non-PWM.
// - Counter write blocks matches on next tick.
// - Wave outputs survive waveform mode changes.
// - Output action unbuffered, governs next match.
// - Reset clears wave output states.
// - Nonzero action overrides pin; direction still rules.
// - Output action zero leaves wave output alone.
// - Action: set/clear/toggle, or in PWM modes polarity or toggle on match.
// - Normal mode increments, wraps 0xFF to 0x00.
// - Normal mode overflow flag set when counter hits zero.
// - Overflow flag cleared by ack; follows mode.
// - Counter gives count, direction, clear, top, bottom.
// - Select 1 system clock; 2..5 prescaler taps.
// - Select 7 rising, 6 falling external edges.
// - Top fixed 0xFF or compare A by mode.
`timescale 1ns/100ps
`default_nettype none

module tmr8_core
	import tmr8_pkg::*;
#(
	parameter int WIDTH = TMR8_WIDTH
)
(
	input wire logic core_clk,
	input wire logic reset_n,
	input wire logic [2:0] clock_select,
	input wire logic [1:0] waveform_mode_low,
	input wire logic waveform_mode_bit2,
	input wire logic external_count_pin,
	input wire logic counter_write,
	input wire logic [WIDTH-1:0] counter_write_data,
	output logic [WIDTH-1:0] counter_value,
	input wire logic compare_a_write,
	input wire logic compare_b_write,
	input wire logic [WIDTH-1:0] compare_write_data,
	output logic [WIDTH-1:0] compare_a_value,
	output logic [WIDTH-1:0] compare_b_value,
	input wire logic [1:0] output_action_a,
	input wire logic [1:0] output_action_b,
	input wire logic force_match_a,
	input wire logic force_match_b,
	input wire logic [2:0] flag_clear,
	input wire logic [2:0] interrupt_ack,
	input wire logic [2:0] interrupt_enable,
	output logic overflow_flag,
	output logic compare_a_flag,
	output logic compare_b_flag,
	output logic [2:0] interrupt_request,
	input wire logic pin_direction_a,
	input wire logic pin_direction_b,
	input wire logic port_value_a,
	input wire logic port_value_b,
	output logic pin_out_a,
	output logic pin_out_b,
	output logic pin_oe_a,
	output logic pin_oe_b,
	output logic wave_output_a,
	output logic wave_output_b
);

	// ------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------
	typedef enum logic {TMR8_UP = 1'b0, TMR8_DOWN = 1'b1} tmr8_dir_e; // Count direction
	logic [2:0] waveform_mode; // Combined mode
	logic timer_tick; // One-cycle count enable
	tmr8_dir_e direction; // Current direction
	logic [WIDTH-1:0] top_value; // Highest count
	logic at_top; // Counter equals top
	logic at_bottom; // Counter equals zero
	logic at_max; // Counter equals max
	logic pwm_mode; // Any PWM mode
	logic phase_mode; // Dual slope
	logic fast_mode; // Single slope
	logic [WIDTH-1:0] next_counter; // Counter after this tick
	logic count_clear; // Clear on this tick
	logic write_block; // Matches blocked one tick
	logic [WIDTH-1:0] buffer_a; // Compare A buffer
	logic [WIDTH-1:0] buffer_b; // Compare B buffer
	logic buffer_load; // Transfer buffers now
	logic match_a; // Raw compare A equality
	logic match_b; // Raw compare B equality
	logic event_a; // Real match at tick
	logic event_b; // Real match at tick
	logic set_ovf; // Overflow event
	assign waveform_mode = {waveform_mode_bit2, waveform_mode_low};
	assign pwm_mode = (waveform_mode_low != 2'h0) && (waveform_mode_low != 2'h2);
	assign phase_mode = (waveform_mode_low == 2'h1);
	assign fast_mode = (waveform_mode_low == 2'h3);

	// ------------------------------------------------------------
	// Tick source
	// ------------------------------------------------------------
	tmr8_tick_gen u_tick (
		.core_clk(core_clk),
		.reset_n(reset_n),
		.clock_select(clock_select),
		.external_count_pin(external_count_pin),
		.timer_tick(timer_tick)
	);

	// ------------------------------------------------------------
	// Counter unit
	// ------------------------------------------------------------
	// Top from mode: compare A when bit 2 set or CLEAR_ON_MATCH_MODE, else fixed
	assign top_value = (waveform_mode_bit2 || waveform_mode == TMR8_WM_CTC) ?
		compare_a_value : TMR8_MAX;
	assign at_top = (counter_value == top_value);
	assign at_bottom = (counter_value == TMR8_BOTTOM);
	assign at_max = (counter_value == TMR8_MAX);
	// Normal mode never clears; CLEAR_ON_MATCH_MODE and fast clear after top
	assign count_clear = (waveform_mode == TMR8_WM_CTC || fast_mode) && at_top;

	// Next count for a tick
	always_comb begin
		if (count_clear) begin
			next_counter = TMR8_BOTTOM;
		end else if (phase_mode && (direction == TMR8_DOWN || at_top) && !at_bottom) begin
			next_counter = counter_value - 1'b1;
		end else begin
			next_counter = counter_value + 1'b1;
		end
	end

	// Counter; CPU write has priority over any tick
	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			counter_value <= TMR8_CNT_RESET;
		end else if (counter_write) begin
			counter_value <= counter_write_data;
		end else if (timer_tick) begin
			counter_value <= next_counter;
		end
	end

	// Direction only turns in dual slope mode
	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			direction <= TMR8_UP;
		end else if (!phase_mode) begin
			direction <= TMR8_UP;
		end else if (timer_tick && !counter_write) begin
			if (at_top) begin
				direction <= TMR8_DOWN;
			end else if (at_bottom) begin
				direction <= TMR8_UP;
			end
		end
	end

	// Block matches from a counter write until the next tick passes
	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			write_block <= 1'b0;
		end else if (counter_write) begin
			write_block <= 1'b1;
		end else if (timer_tick) begin
			write_block <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// Compare registers with optional buffering
	// ------------------------------------------------------------
	// Buffers load at top (fast) or top (dual slope) of the sequence
	assign buffer_load = timer_tick && !counter_write && at_top && pwm_mode;

	// CPU write target depends on buffering
	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			buffer_a <= TMR8_CMP_RESET;
			buffer_b <= TMR8_CMP_RESET;
			compare_a_value <= TMR8_CMP_RESET;
			compare_b_value <= TMR8_CMP_RESET;
		end else begin
			if (compare_a_write) begin
				buffer_a <= compare_write_data;
			end
			if (compare_b_write) begin
				buffer_b <= compare_write_data;
			end
			if (!pwm_mode) begin // Buffering bypassed: write lands directly
				if (compare_a_write) begin
					compare_a_value <= compare_write_data;
				end
				if (compare_b_write) begin
					compare_b_value <= compare_write_data;
				end
			end else if (buffer_load) begin
				compare_a_value <= compare_a_write ? compare_write_data : buffer_a;
				compare_b_value <= compare_b_write ? compare_write_data : buffer_b;
			end
		end
	end

	// ------------------------------------------------------------
	// Match events and flags
	// ------------------------------------------------------------
	assign match_a = (counter_value == compare_a_value);
	assign match_b = (counter_value == compare_b_value);
	assign event_a = timer_tick && match_a && !write_block && !counter_write;
	assign event_b = timer_tick && match_b && !write_block && !counter_write;
	// Overflow: normal/CLEAR_ON_MATCH_MODE at max->0, fast at top, phase at bottom
	assign set_ovf = timer_tick && !counter_write && ((!pwm_mode && at_max) ||
		(fast_mode && at_top) || (phase_mode && at_bottom && direction == TMR8_DOWN));

	// Sticky flags; a set beats a simultaneous clear
	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			overflow_flag <= 1'b0;
			compare_a_flag <= 1'b0;
			compare_b_flag <= 1'b0;
		end else begin
			overflow_flag <= set_ovf | (overflow_flag & ~flag_clear[0] & ~interrupt_ack[0]);
			compare_a_flag <= event_a | (compare_a_flag & ~flag_clear[1] & ~interrupt_ack[1]);
			compare_b_flag <= event_b | (compare_b_flag & ~flag_clear[2] & ~interrupt_ack[2]);
		end
	end

	assign interrupt_request = {compare_b_flag, compare_a_flag, overflow_flag} &
		interrupt_enable;

	// ------------------------------------------------------------
	// Waveform outputs
	// ------------------------------------------------------------
	// Next wave state per unit; mode change keeps the register as is
	function automatic logic tmr8_wave(input logic cur, input logic [1:0] act,
		input logic pwm, input logic fast, input logic ev, input logic frc,
		input logic bot, input tmr8_dir_e dir, input logic tick);
		logic nxt;
		nxt = cur;
		if (act == TMR8_OA_NONE) begin
			nxt = cur;
		end else if (!pwm) begin
			if (ev || frc) begin
				unique case (act)
					TMR8_OA_TOGGLE: nxt = ~cur;
					TMR8_OA_CLEAR: nxt = 1'b0;
					TMR8_OA_SET: nxt = 1'b1;
					default: nxt = cur;
				endcase
			end
		end else if (act == TMR8_OA_TOGGLE) begin
			nxt = ev ? ~cur : cur;
		end else if (fast) begin
			if (ev) begin
				nxt = (act == TMR8_OA_SET);
			end else if (tick && bot) begin
				nxt = (act == TMR8_OA_CLEAR);
			end
		end else if (ev) begin
			nxt = (act == TMR8_OA_SET) ^ (dir == TMR8_DOWN);
		end
		return nxt;
	endfunction : tmr8_wave

	// Wave state registers, zero after reset
	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			wave_output_a <= 1'b0;
			wave_output_b <= 1'b0;
		end else begin // Action read live so a new setting rules the next match
			wave_output_a <= tmr8_wave(wave_output_a, output_action_a, pwm_mode, fast_mode,
				event_a, force_match_a & ~pwm_mode, next_counter == TMR8_BOTTOM,
				direction, timer_tick);
			wave_output_b <= tmr8_wave(wave_output_b, output_action_b, pwm_mode, fast_mode,
				event_b, force_match_b & ~pwm_mode, next_counter == TMR8_BOTTOM,
				direction, timer_tick);
		end
	end

	// Pin override regardless of mode; direction still from port
	assign pin_out_a = (output_action_a != TMR8_OA_NONE) ? wave_output_a : port_value_a;
	assign pin_out_b = (output_action_b != TMR8_OA_NONE) ? wave_output_b : port_value_b;
	assign pin_oe_a = pin_direction_a;
	assign pin_oe_b = pin_direction_b;

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	sequence cnt_write_s;
		counter_write;
	endsequence
	sequence next_tick_s;
		timer_tick && !counter_write;
	endsequence
	write_wins_a: assert property (@(posedge core_clk) disable iff (!reset_n)
		cnt_write_s |=> counter_value == $past(counter_write_data))
		else $error("counter write lost");
	stop_hold_a: assert property (@(posedge core_clk) disable iff (!reset_n)
		clock_select == TMR8_CS_STOP && !counter_write |=> $stable(counter_value))
		else $error("counter moved while stopped");
	normal_wrap_a: assert property (@(posedge core_clk) disable iff (!reset_n)
		waveform_mode == TMR8_WM_NORMAL && timer_tick && !counter_write
		|=> counter_value == $past(counter_value) + 8'h01)
		else $error("normal mode not incrementing");
	ovf_on_zero_a: assert property (@(posedge core_clk) disable iff (!reset_n)
		waveform_mode == TMR8_WM_NORMAL && timer_tick && !counter_write && at_max
		|=> overflow_flag && counter_value == TMR8_BOTTOM)
		else $error("overflow flag missed");
	flag_set_a: assert property (@(posedge core_clk) disable iff (!reset_n)
		timer_tick && match_a && !write_block && !counter_write |=> compare_a_flag)
		else $error("compare a flag missed");
	// First tick after a counter write may not raise either compare flag
	write_block_a: assert property (@(posedge core_clk) disable iff (!reset_n)
		write_block ##0 next_tick_s ##0 (!compare_a_flag && !compare_b_flag)
		|=> !compare_a_flag && !compare_b_flag)
		else $error("match not blocked");
	force_no_flag_a: assert property (@(posedge core_clk) disable iff (!reset_n)
		force_match_a && !pwm_mode && !event_a && !compare_a_flag |=> !compare_a_flag)
		else $error("force set the flag");
	action_none_a: assert property (@(posedge core_clk) disable iff (!reset_n)
		output_action_a == TMR8_OA_NONE |=> $stable(wave_output_a))
		else $error("wave changed with no action");
	irq_gate_a: assert property (@(posedge core_clk) disable iff (!reset_n)
		interrupt_request[1] == (compare_a_flag && interrupt_enable[1]))
		else $error("request not gated by enable");
	ack_clear_a: assert property (@(posedge core_clk) disable iff (!reset_n)
		interrupt_ack[0] && !set_ovf |=> !overflow_flag)
		else $error("overflow ack did not clear");

endmodule : tmr8_core

`default_nettype wire

// File: logic/tmr8_pkg.sv
// Constants shared by the 8-bit timer core and its tick generator.
// Assumes a single 10 MHz core clock and plain port access to all settings.
package tmr8_pkg;

	// ------------------------------------------------------------
	// Widths and fixed values
	// ------------------------------------------------------------
	localparam int TMR8_WIDTH = 8; // Counter and compare width
	localparam logic [7:0] TMR8_MAX = 8'hff; // Fixed top value
	localparam logic [7:0] TMR8_BOTTOM = 8'h00; // Bottom value
	localparam logic [7:0] TMR8_CNT_RESET = 8'h00; // Counter after reset
	localparam logic [7:0] TMR8_CMP_RESET = 8'h00; // Compare values after reset

	// ------------------------------------------------------------
	// Clock select codes
	// ------------------------------------------------------------
	localparam logic [2:0] TMR8_CS_STOP = 3'h0; // No source, timer stopped
	localparam logic [2:0] TMR8_CS_DIV1 = 3'h1; // System clock
	localparam logic [2:0] TMR8_CS_DIV8 = 3'h2; // Prescaler tap /8
	localparam logic [2:0] TMR8_CS_DIV64 = 3'h3; // Prescaler tap /64
	localparam logic [2:0] TMR8_CS_DIV256 = 3'h4; // Prescaler tap /256
	localparam logic [2:0] TMR8_CS_DIV1024 = 3'h5; // Prescaler tap /1024
	localparam logic [2:0] TMR8_CS_EXT_FALL = 3'h6; // External falling edge
	localparam logic [2:0] TMR8_CS_EXT_RISE = 3'h7; // External rising edge
	localparam int TMR8_PRESCALE_W = 10; // Prescaler counter width

	// ------------------------------------------------------------
	// Waveform modes
	// ------------------------------------------------------------
	localparam logic [2:0] TMR8_WM_NORMAL = 3'h0; // Count up, wrap
	localparam logic [2:0] TMR8_WM_PC_MAX = 3'h1; // Phase correct, top fixed
	localparam logic [2:0] TMR8_WM_CTC = 3'h2; // Clear on match A
	localparam logic [2:0] TMR8_WM_FAST_MAX = 3'h3; // Fast PWM, top fixed
	localparam logic [2:0] TMR8_WM_PC_CMP = 3'h5; // Phase correct, top compare A
	localparam logic [2:0] TMR8_WM_FAST_CMP = 3'h7; // Fast PWM, top compare A

	// ------------------------------------------------------------
	// Output action codes
	// ------------------------------------------------------------
	localparam logic [1:0] TMR8_OA_NONE = 2'h0; // No action
	localparam logic [1:0] TMR8_OA_TOGGLE = 2'h1; // Toggle on match
	localparam logic [1:0] TMR8_OA_CLEAR = 2'h2; // Clear / non-inverted
	localparam logic [1:0] TMR8_OA_SET = 2'h3; // Set / inverted

endpackage : tmr8_pkg

// File: logic/tmr8_tick_gen.sv
// Timer tick generator: free running prescaler and external pin edge detect.
// Assumes the external count pin is already synchronous to core_clk.
`timescale 1ns/100ps
`default_nettype none

module tmr8_tick_gen
	import tmr8_pkg::*;
(
	input wire logic core_clk,
	input wire logic reset_n,
	input wire logic [2:0] clock_select,
	input wire logic external_count_pin,
	output logic timer_tick
);

	// ------------------------------------------------------------
	// Prescaler and pin history
	// ------------------------------------------------------------
	logic [TMR8_PRESCALE_W-1:0] prescale; // Free running divider
	logic pin_last; // Pin one cycle ago

	// Prescaler never stops, so first tick lands 1..N cycles after enable
	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			prescale <= '0;
		end else begin
			prescale <= prescale + 1'b1;
		end
	end

	// Pin history for edge detection
	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			pin_last <= 1'b0;
		end else begin
			pin_last <= external_count_pin;
		end
	end

	// Tick select; zero gives nothing at all
	always_comb begin
		unique case (clock_select)
			TMR8_CS_STOP: timer_tick = 1'b0;
			TMR8_CS_DIV1: timer_tick = 1'b1;
			TMR8_CS_DIV8: timer_tick = &prescale[2:0];
			TMR8_CS_DIV64: timer_tick = &prescale[5:0];
			TMR8_CS_DIV256: timer_tick = &prescale[7:0];
			TMR8_CS_DIV1024: timer_tick = &prescale[9:0];
			TMR8_CS_EXT_FALL: timer_tick = pin_last & ~external_count_pin;
			TMR8_CS_EXT_RISE: timer_tick = ~pin_last & external_count_pin;
		endcase
	end

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	stopped_no_tick_a: assert property (@(posedge core_clk) disable iff (!reset_n)
		clock_select == TMR8_CS_STOP |-> !timer_tick)
		else $error("tick while stopped");

	div8_spacing_a: assert property (@(posedge core_clk) disable iff (!reset_n)
		(clock_select == TMR8_CS_DIV8 && timer_tick) ##1 (clock_select == TMR8_CS_DIV8) [*7]
		|-> ##0 !$past(timer_tick) && !timer_tick)
		else $error("div8 tick too early");

endmodule : tmr8_tick_gen

`default_nettype wire

// File: verification/tmr8_core_tb.sv
// Self-checking bench for the 8-bit timer core: force table, then hand tests.
// Assumes the core at default width and the pad model on output A.
`timescale 1ns/100ps
`default_nettype none

module tmr8_core_tb
	import tmr8_pkg::*;
;
	// --------------------------------------------------------------
	// Stimulus and observed signals
	// --------------------------------------------------------------
	logic core_clk = 1'b0;
	logic reset_n = 1'b0;
	logic [2:0] sel, fclr, ack, ien;
	logic [1:0] wml, oa_a, oa_b;
	logic wm2, ext, cw, caw, cbw, fa, fb, dir_a, dir_b, pv_a, pv_b, e;
	logic [7:0] cwd, cmpd, c;
	wire logic [7:0] cnt, cmp_a, cmp_b;
	wire logic ovf, fla, flb, wa, wb, po_a, po_b, oe_a, oe_b, lvl_a;
	wire logic [2:0] irq;
	int n_fail = 0;
	int n_checks = 0;
	int k;
	int div [4] = '{8, 64, 256, 1024}; // Prescaler tap ratios
	// Force cases: action, pin direction, wave state afterwards
	typedef struct packed {logic [1:0] oa; logic dir; logic wave;} tmr8_row_s;
	tmr8_row_s rows [5] = '{'{TMR8_OA_SET, 1'b0, 1'b1}, '{TMR8_OA_NONE, 1'b1, 1'b1},
		'{TMR8_OA_TOGGLE, 1'b1, 1'b0}, '{TMR8_OA_TOGGLE, 1'b1, 1'b1},
		'{TMR8_OA_CLEAR, 1'b1, 1'b0}};

	// 10 MHz clock
	always #50 core_clk = ~core_clk;

	tmr8_core dut_u (
		.core_clk(core_clk), .reset_n(reset_n), .clock_select(sel),
		.waveform_mode_low(wml), .waveform_mode_bit2(wm2), .external_count_pin(ext),
		.counter_write(cw), .counter_write_data(cwd), .counter_value(cnt),
		.compare_a_write(caw), .compare_b_write(cbw), .compare_write_data(cmpd),
		.compare_a_value(cmp_a), .compare_b_value(cmp_b),
		.output_action_a(oa_a), .output_action_b(oa_b),
		.force_match_a(fa), .force_match_b(fb), .flag_clear(fclr),
		.interrupt_ack(ack), .interrupt_enable(ien), .overflow_flag(ovf),
		.compare_a_flag(fla), .compare_b_flag(flb), .interrupt_request(irq),
		.pin_direction_a(dir_a), .pin_direction_b(dir_b),
		.port_value_a(pv_a), .port_value_b(pv_b), .pin_out_a(po_a), .pin_out_b(po_b),
		.pin_oe_a(oe_a), .pin_oe_b(oe_b), .wave_output_a(wa), .wave_output_b(wb)
	);
	tmr8_pin_model pin_u (.pin_out(po_a), .pin_oe(oe_a), .pin_level(lvl_a));

	// --------------------------------------------------------------
	// Tasks
	// --------------------------------------------------------------
	// Inputs move 1 ns after the edge, so the core never races them
	task automatic step(input int n = 1);
		repeat (n) begin
			@(posedge core_clk);
			#1;
		end
	endtask : step

	task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
		n_checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("unexpected %s: expected %h, seen %h", what, exp, seen);
		end
	endtask : chk

	task automatic wr_cnt(input logic [7:0] d);
		cw = 1'b1;
		cwd = d;
		step();
		cw = 1'b0;
	endtask : wr_cnt

	task automatic wr_cmp(input logic b, input logic [7:0] d);
		caw = !b;
		cbw = b;
		cmpd = d;
		step();
		{caw, cbw} = 2'b00;
	endtask : wr_cmp

	// Trailing idle cycle keeps two strobes from meeting in one time step
	task automatic frc_a();
		fa = 1'b1;
		step();
		fa = 1'b0;
		step();
	endtask : frc_a

	task automatic chk_rst();
		chk("cnt", cnt, 0);
		chk("cmp_a", cmp_a, 0);
		chk("cmp_b", cmp_b, 0);
		chk("flags", {ovf, fla, flb, irq}, 0);
		chk("waves", {wa, wb}, 0);
	endtask : chk_rst

	task automatic print_verdict();
		if (n_fail == 0 && n_checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : print_verdict

	// Watchdog: the tests need a few thousand cycles
	initial begin
		#(20000 * 100);
		n_fail++;
		print_verdict();
	end

	// --------------------------------------------------------------
	// Main sequence
	// --------------------------------------------------------------
	initial begin
		{sel, fclr, ack, ien, wml, oa_a, oa_b, wm2, ext, cw, caw, cbw} = '0;
		{fa, fb, dir_a, dir_b, pv_a, pv_b, cwd, cmpd} = '0;
		step(2);
		reset_n = 1'b1;
		chk_rst();
		// Timer stopped: forced matches drive the wave, pin follows direction
		foreach (rows[i]) begin
			oa_a = rows[i].oa;
			dir_a = rows[i].dir;
			frc_a();
			e = !rows[i].dir ? 1'b1 : (rows[i].oa != TMR8_OA_NONE ? rows[i].wave : pv_a);
			chk("wave_a", wa, rows[i].wave);
			chk("pin_oe_a", oe_a, rows[i].dir);
			chk("pin_a", lvl_a, e);
			chk("flag_a", fla, 0);
			chk("cnt", cnt, 0);
		end
		// Wave state survives a mode change
		oa_a = TMR8_OA_SET;
		frc_a();
		wml = TMR8_WM_CTC[1:0];
		step(2);
		chk("wave_a", wa, 1);
		wml = TMR8_WM_NORMAL[1:0];
		// Normal count, write priority, wrap and overflow
		sel = TMR8_CS_DIV1;
		ien = 3'h7;
		step();
		wr_cnt(8'hfd);
		chk("cnt", cnt, 8'hfd);
		for (k = 1; k <= 3; k++) begin
			step();
			chk("cnt", cnt, 8'(8'hfd + k));
			chk("ovf", ovf, k == 3);
		end
		chk("irq_ovf", irq[0], 1);
		ack = 3'h1;
		step();
		ack = 3'h0;
		chk("ovf", ovf, 0);
		// Compare match sets the flag one tick later
		wr_cmp(1'b0, 8'h10);
		chk("cmp_a", cmp_a, 8'h10);
		chk("irq_b", irq[2], 1);
		fclr = 3'h6;
		step();
		fclr = 3'h0;
		wr_cnt(8'h0e);
		step(2);
		chk("flag_a", fla, 0);
		step();
		chk("flag_a", fla, 1);
		chk("irq_a", irq[1], 1);
		fclr = 3'h2;
		step();
		fclr = 3'h0;
		chk("flag_a", fla, 0);
		// Counter write while stopped hides the match at the next tick
		sel = TMR8_CS_STOP;
		wr_cmp(1'b1, 8'h20);
		chk("cmp_b", cmp_b, 8'h20);
		wr_cnt(8'h20);
		step(2);
		sel = TMR8_CS_DIV1;
		step(3);
		chk("flag_b", flb, 0);
		// Fast PWM: buffered compare, force refused
		sel = TMR8_CS_STOP;
		wml = TMR8_WM_FAST_MAX[1:0];
		step();
		wr_cmp(1'b0, 8'h40);
		chk("cmp_a", cmp_a, 8'h10);
		oa_a = TMR8_OA_TOGGLE;
		frc_a();
		chk("wave_a", wa, 1);
		sel = TMR8_CS_DIV1;
		step();
		wr_cnt(8'hfd);
		step(2);
		chk("cmp_a", cmp_a, 8'h10);
		step();
		chk("cmp_a", cmp_a, 8'h40);
		// Phase correct: up to the fixed top, then down again
		wml = TMR8_WM_PC_MAX[1:0];
		wr_cnt(8'hfe);
		for (k = 1; k <= 3; k++) begin
			step();
			chk("cnt_pc", cnt, 16'(256 - k));
		end
		// Prescaler taps: cycles between two ticks
		wml = TMR8_WM_NORMAL[1:0];
		foreach (div[i]) begin
			sel = TMR8_CS_DIV8 + 3'(i);
			c = cnt;
			k = 0;
			while (cnt === c && k < 2100) begin
				step();
				k++;
			end
			c = cnt;
			k = 0;
			do begin
				step();
				k++;
			end while (cnt === c && k < 2100);
			chk("tick_gap", 16'(k), 16'(div[i]));
		end
		// External pin, rising then falling edge selection
		sel = TMR8_CS_STOP;
		step(2);
		for (k = 7; k >= 6; k--) begin
			sel = 3'(k);
			step(2);
			c = cnt;
			ext = 1'b1;
			step(5);
			chk("cnt_ext", cnt, 8'(c + (k == 7)));
			ext = 1'b0;
			step(5);
			chk("cnt_ext", cnt, 8'(c + 1));
		end
		// Reset in mid-run clears everything again
		sel = TMR8_CS_STOP;
		oa_b = TMR8_OA_SET;
		fb = 1'b1;
		step();
		fb = 1'b0;
		dir_b = 1'b1;
		step();
		chk("wave_b", wb, 1);
		chk("pin_b", {oe_b, po_b}, 2'b11);
		reset_n = 1'b0;
		step(2);
		chk_rst();
		reset_n = 1'b1;
		step(2);
		chk_rst();
		chk("pin_b", {oe_b, po_b}, 2'b10);
		print_verdict();
	end
endmodule : tmr8_core_tb

`default_nettype wire

// File: verification/tmr8_pin_model.sv
// Pad model for one compare output pin of the timer core.
// Assumes a weak pull-up on the pad and a single driver, the core.
`timescale 1ns/100ps
`default_nettype none

module tmr8_pin_model (
	input wire logic pin_out,
	input wire logic pin_oe,
	output logic pin_level
);
	// Released pad goes to the pull-up, never keeps the last driven value
	assign pin_level = pin_oe ? pin_out : 1'b1;
endmodule : tmr8_pin_model

`default_nettype wire
